// [dv/rbv_src_model.sv]
`timescale 1ns/1ps
module rbv_src_model (
  input  wire logic            ref_clk,
  input  wire logic [3:0]      srcSel,
  input  wire logic            srcGo,
  input  wire logic            resetPinNOe,
  output rbv_pkg::rbv_src_type srcReq,
  output logic                 resetPinNIn,
  output logic                 pinWire
);
  logic press;
  // Code 8 is a press on the pin; codes 0..7 are the internal sources
  assign press = srcGo && (srcSel == 4'h8);
  assign srcReq = (srcGo && srcSel < 4'h8) ? (8'h80 >> srcSel) : 8'h00;
  // Pull-up wire; the device's own drive is not looped back, it would latch reset
  assign pinWire = !(press || resetPinNOe);
  assign resetPinNIn = !press;
endmodule

// [dv/reset_and_boot_vector_control_test.sv]
`timescale 1ns/1ps
module reset_and_boot_vector_control_test;
  localparam logic [15:0] BOOT_VEC = 16'h1c40;
  typedef struct packed {logic [15:0] vec; logic [7:0] cause;} rbv_note_type;
  localparam rbv_pkg::rbv_sys_type SYS_RUN = {6'b111001, rbv_pkg::WDT_TIMEOUT_MAX, 2'h0};
  localparam rbv_pkg::rbv_sys_type SYS_RST = {6'b111111, rbv_pkg::WDT_TIMEOUT_MAX, 2'h0};
  logic ref_clk, rst, cfgWe, porCfgWe, srcGo, resetPinNIn, pinWire;
  logic resetPinNOut, resetPinNOe, coreHalt, sysResetActive, vectorValid, ramWriteInhibit;
  logic [3:0] srcSel;
  logic [7:0] sigByte, cfgIn, porCfgIn, cfgReg, porCfgReg, resetCause, cfgVal, porVal;
  logic [15:0] startVector;
  rbv_pkg::rbv_src_type srcReq;
  rbv_pkg::rbv_sys_type sysCfg;
  rbv_note_type noteQ[$];
  rbv_note_type note;
  int err_total = 0;
  int comparisons = 0;

  rbv_reset_boot_ctrl #(.BOOT_VECTOR(BOOT_VEC)) uut (.ref_clk(ref_clk), .rst(rst),
    .srcReq(srcReq), .resetPinNIn(resetPinNIn), .sigByte(sigByte), .cfgIn(cfgIn),
    .cfgWe(cfgWe), .porCfgIn(porCfgIn), .porCfgWe(porCfgWe), .resetPinNOut(resetPinNOut),
    .resetPinNOe(resetPinNOe), .coreHalt(coreHalt), .sysResetActive(sysResetActive),
    .vectorValid(vectorValid), .startVector(startVector), .ramWriteInhibit(ramWriteInhibit),
    .sysCfg(sysCfg), .cfgReg(cfgReg), .porCfgReg(porCfgReg), .resetCause(resetCause));
  rbv_src_model srcModel (.ref_clk(ref_clk), .srcSel(srcSel), .srcGo(srcGo),
    .resetPinNOe(resetPinNOe), .srcReq(srcReq), .resetPinNIn(resetPinNIn), .pinWire(pinWire));

  always #5 ref_clk = ~ref_clk;

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Compared %0d, mismatched %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wait_pulse();
    for (int k = 0; k < 40 && noteQ.size() > 0; k++) @(posedge ref_clk);
    check("pulseSeen", 16'(noteQ.size()), 16'h0);
  endtask

  task automatic do_reset(input logic [3:0] sel, input logic [7:0] sig, input bit glitch);
    sigByte <= sig;
    srcSel <= sel;
    srcGo <= 1'b1;
    // Register writes raised inside reset must be refused
    @(posedge ref_clk);
    cfgWe <= 1'b1;
    porCfgWe <= 1'b1;
    @(posedge ref_clk);
    cfgWe <= 1'b0;
    porCfgWe <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("haltIn", coreHalt, 1'b1);
    check("sysRstIn", sysResetActive, 1'b1);
    check("ramIn", ramWriteInhibit, 1'b1);
    check("sysIn", sysCfg, SYS_RST);
    check("pinIn", pinWire, !(sel == 0 || sel == 4 || sel == 8));
    noteQ.push_back({(sig == rbv_pkg::BOOT_SIGNATURE) ? BOOT_VEC : rbv_pkg::RESET_VECTOR,
                     (sel == 8) ? 8'h40 : 8'h80 >> sel});
    @(posedge ref_clk);
    srcGo <= 1'b0;
    if (glitch) begin
      repeat (4) @(posedge ref_clk);
      srcGo <= 1'b1;
      @(posedge ref_clk);
      srcGo <= 1'b0;
    end
    wait_pulse();
  endtask

  // Every pulse must match the oldest note; an extra pulse is a fault
  always @(posedge ref_clk) begin
    #1;
    if (vectorValid === 1'b1) begin
      if (noteQ.size() == 0) begin
        check("extraPulse", 16'h1, 16'h0);
      end else begin
        note = noteQ.pop_front();
        check("vector", startVector, note.vec);
        check("cause", resetCause, note.cause);
        check("haltOut", coreHalt, 1'b0);
        check("sysRstOut", sysResetActive, 1'b0);
        check("sysOut", sysCfg, SYS_RUN);
        check("pinOut", pinWire, 1'b1);
        check("pinLevel", resetPinNOut, 1'b0);
      end
    end
  end

  initial begin
    #200us;
    err_total++;
    report_and_stop();
  end

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    cfgWe = 1'b0;
    porCfgWe = 1'b0;
    srcGo = 1'b0;
    srcSel = 4'h0;
    sigByte = 8'h00;
    cfgIn = 8'h00;
    porCfgIn = 8'h00;
    void'($urandom(32'h00a1c89e));
    repeat (7) @(posedge ref_clk);
    #1;
    check("pinPor", pinWire, 1'b0);
    check("haltPor", coreHalt, 1'b1);
    noteQ.push_back({rbv_pkg::RESET_VECTOR, rbv_pkg::CAUSE_RST});
    @(posedge ref_clk);
    rst <= 1'b0;
    wait_pulse();
    for (int s = 0; s < 9; s++) begin
      do_reset(4'(s), s[0] ? rbv_pkg::BOOT_SIGNATURE : 8'($urandom), 1'b0);
    end
    for (int n = 0; n < 8; n++) begin
      do_reset(4'($urandom_range(8)), n[0] ? rbv_pkg::BOOT_SIGNATURE : 8'($urandom), n[1]);
    end
    // Ordinary and power-on-only registers through a soft and a power-on reset
    cfgVal = 8'($urandom) | 8'h01;
    porVal = 8'($urandom) | 8'h01;
    @(posedge ref_clk);
    cfgIn <= cfgVal;
    porCfgIn <= porVal;
    cfgWe <= 1'b1;
    porCfgWe <= 1'b1;
    @(posedge ref_clk);
    cfgWe <= 1'b0;
    porCfgWe <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("cfgWr", cfgReg, cfgVal);
    check("porWr", porCfgReg, porVal);
    // A different input value shows whether a refused write slipped through
    @(posedge ref_clk);
    porCfgIn <= ~porVal;
    do_reset(4'h3, 8'h00, 1'b0);
    check("cfgSw", cfgReg, rbv_pkg::CFG_RESET_VAL);
    check("porSw", porCfgReg, porVal);
    do_reset(4'h0, 8'h00, 1'b0);
    check("porPor", porCfgReg, rbv_pkg::POR_CFG_RST);
    report_and_stop();
  end
endmodule

// [verilog/rbv_pkg.sv]
// Operation
// - Core halted while reset is active
// - Registers load defaults; power-on-only bits kept otherwise
// - Interrupts and timers disabled by reset
// - Data memory contents untouched by reset
// - Port latches one, drivers open-drain
// - Weak pull-ups on during and after reset
// - Pin driven low for power-on, supply resets
// - Program counter cleared, internal oscillator selected
// - Watchdog enabled and running after reset
// - Any of eight sources enters reset
// - Signature 0xa5 below lock byte means bootloader
// - Bootloader present: start at bootloader vector
// - Bootloader absent: start at address zero
// - Watchdog timeout defaults to longest interval
// - Watchdog reset leaves reset pin alone
package rbv_pkg;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  BOOT_SIGNATURE  = 8'ha5;
  localparam logic [15:0] RESET_VECTOR    = 16'h0000;
  localparam logic [15:0] BOOT_VECTOR_DEF = 16'h3a00;
  localparam logic [2:0]  WDT_TIMEOUT_MAX = 3'h7;
  localparam logic [7:0]  PORT_LATCH_RST  = 8'hff;
  localparam logic [1:0]  CLK_SEL_INTOSC  = 2'h0;
  localparam logic [7:0]  CFG_RESET_VAL   = 8'h00;
  localparam logic [7:0]  POR_CFG_RST     = 8'h00;
  localparam logic [7:0]  CAUSE_RST       = 8'h80;
  localparam int          RELEASE_CYCLES  = 4;
  localparam logic [2:0]  RELEASE_COUNT   = 3'(RELEASE_CYCLES);

  // Source bit order in the cause vector
  localparam int SRC_POR  = 0;
  localparam int SRC_PIN  = 1;
  localparam int SRC_CMP  = 2;
  localparam int SRC_SW   = 3;
  localparam int SRC_SUP  = 4;
  localparam int SRC_WDT  = 5;
  localparam int SRC_MCD  = 6;
  localparam int SRC_FLSH = 7;

  typedef struct packed {
    logic       porReq;
    logic       pinReq;
    logic       cmpReq;
    logic       swReq;
    logic       supplyReq;
    logic       wdtReq;
    logic       clkMissReq;
    logic       flashErrReq;
  } rbv_src_type;

  typedef struct packed {
    logic       portLatchOne;
    logic       portOpenDrain;
    logic       weakPullupEn;
    logic       irqDisable;
    logic       timerDisable;
    logic       wdtEnable;
    logic [2:0] wdtTimeout;
    logic [1:0] clkSel;
  } rbv_sys_type;

  typedef enum logic [1:0] {ST_RESET, ST_SYNC, ST_FETCH, ST_RUN} rbv_state_type;

endpackage

// [verilog/rbv_reset_boot_ctrl.sv]
`timescale 1ns/1ps
module rbv_reset_boot_ctrl #(
  parameter logic [15:0] BOOT_VECTOR = rbv_pkg::BOOT_VECTOR_DEF
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire rbv_pkg::rbv_src_type srcReq,
  input  wire logic                resetPinNIn,
  input  wire logic [7:0]          sigByte,
  input  wire logic [7:0]          cfgIn,
  input  wire logic                cfgWe,
  input  wire logic [7:0]          porCfgIn,
  input  wire logic                porCfgWe,
  output logic                     resetPinNOut,
  output logic                     resetPinNOe,
  output logic                     coreHalt,
  output logic                     sysResetActive,
  output logic                     vectorValid,
  output logic [15:0]              startVector,
  output logic                     ramWriteInhibit,
  output rbv_pkg::rbv_sys_type      sysCfg,
  output logic [7:0]               cfgReg,
  output logic [7:0]               porCfgReg,
  output logic [7:0]               resetCause
);

  // ----------------------------------------------------------------
  // Source gathering
  // ----------------------------------------------------------------
  logic anySrc;
  logic drivePinSrc;
  logic [7:0] srcVec;

  // External pin low is ORed into the pin request bit, whether or not the on-chip drive of the pin is active
  always_comb begin
    srcVec = srcReq;
    srcVec[7 - rbv_pkg::SRC_PIN] = srcReq.pinReq | ~resetPinNIn;
    anySrc = |srcVec;
    drivePinSrc = srcReq.porReq | srcReq.supplyReq;
  end

  // ----------------------------------------------------------------
  // Release sequencing
  // ----------------------------------------------------------------
  rbv_pkg::rbv_state_type stateReg, stateNext;
  logic [2:0]  cntReg, cntNext;
  logic        syncAReg, syncANext, syncBReg, syncBNext;
  logic        drivePinReg, drivePinNext;
  logic        vecValidReg, vecValidNext;
  logic [15:0] vectorReg, vectorNext;
  logic [7:0]  causeReg, causeNext;

  always_comb begin
    stateNext    = stateReg;
    cntNext      = cntReg;
    syncANext    = anySrc;
    syncBNext    = syncAReg;
    drivePinNext = drivePinReg;
    vecValidNext = 1'b0;
    vectorNext   = vectorReg;
    causeNext    = causeReg;
    if (anySrc) begin
      stateNext = rbv_pkg::ST_RESET;
      cntNext   = rbv_pkg::RELEASE_COUNT;
      causeNext = srcVec;
      if (drivePinSrc) begin
        drivePinNext = 1'b1;
      end
    end else begin
      case (stateReg)
        rbv_pkg::ST_RESET: begin
          if (!syncBReg) begin
            stateNext = rbv_pkg::ST_SYNC;
          end
        end
        rbv_pkg::ST_SYNC: begin
          if (syncBReg) begin
            stateNext = rbv_pkg::ST_RESET;
            cntNext   = rbv_pkg::RELEASE_COUNT;
          end else if (cntReg == 3'h1) begin
            stateNext    = rbv_pkg::ST_FETCH;
            drivePinNext = 1'b0;
            vecValidNext = 1'b1;
            if (sigByte == rbv_pkg::BOOT_SIGNATURE) begin
              vectorNext = BOOT_VECTOR;
            end else begin
              vectorNext = rbv_pkg::RESET_VECTOR;
            end
          end else begin
            cntNext = cntReg - 3'h1;
          end
        end
        rbv_pkg::ST_FETCH: begin
          stateNext = rbv_pkg::ST_RUN;
        end
        default: begin
          stateNext = rbv_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stateReg    <= rbv_pkg::ST_RESET;
      cntReg      <= rbv_pkg::RELEASE_COUNT;
      syncAReg    <= 1'b1;
      syncBReg    <= 1'b1;
      drivePinReg <= 1'b1;
      vecValidReg <= 1'b0;
      vectorReg   <= rbv_pkg::RESET_VECTOR;
      causeReg    <= rbv_pkg::CAUSE_RST;
    end else begin
      stateReg    <= stateNext;
      cntReg      <= cntNext;
      syncAReg    <= syncANext;
      syncBReg    <= syncBNext;
      drivePinReg <= drivePinNext;
      vecValidReg <= vecValidNext;
      vectorReg   <= vectorNext;
      causeReg    <= causeNext;
    end
  end

  // ----------------------------------------------------------------
  // Reset-managed registers
  // ----------------------------------------------------------------
  // rst stands for the power-on event; porCfg survives the other sources
  logic       inReset;
  logic [7:0] cfgNext, porCfgNext;

  assign inReset = (stateReg == rbv_pkg::ST_RESET) || (stateReg == rbv_pkg::ST_SYNC);

  always_comb begin
    cfgNext    = cfgReg;
    porCfgNext = porCfgReg;
    if (inReset) begin
      cfgNext = rbv_pkg::CFG_RESET_VAL;
      if (srcReq.porReq) begin
        porCfgNext = rbv_pkg::POR_CFG_RST;
      end
    end else begin
      if (cfgWe) begin
        cfgNext = cfgIn;
      end
      if (porCfgWe) begin
        porCfgNext = porCfgIn;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfgReg    <= rbv_pkg::CFG_RESET_VAL;
      porCfgReg <= rbv_pkg::POR_CFG_RST;
    end else begin
      cfgReg    <= cfgNext;
      porCfgReg <= porCfgNext;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    coreHalt        = inReset;
    sysResetActive  = inReset;
    ramWriteInhibit = inReset;
    resetPinNOut    = 1'b0;
    resetPinNOe     = drivePinReg;
    vectorValid     = vecValidReg;
    startVector     = vectorReg;
    resetCause      = causeReg;
    sysCfg.portLatchOne  = 1'b1;
    sysCfg.portOpenDrain = 1'b1;
    sysCfg.weakPullupEn  = 1'b1;
    sysCfg.irqDisable    = inReset;
    sysCfg.timerDisable  = inReset;
    sysCfg.wdtEnable     = 1'b1;
    sysCfg.wdtTimeout    = rbv_pkg::WDT_TIMEOUT_MAX;
    sysCfg.clkSel        = rbv_pkg::CLK_SEL_INTOSC;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence relQuiet;
    !anySrc [*8];
  endsequence

  chk_halt_on_src: assert property (@(posedge ref_clk) disable iff (rst)
    anySrc |=> coreHalt && sysCfg.irqDisable)
    else $error("core not halted after reset source");
  chk_src_enters: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(anySrc) |=> stateReg == rbv_pkg::ST_RESET)
    else $error("source did not enter reset");
  chk_timers_off: assert property (@(posedge ref_clk) disable iff (rst)
    coreHalt |-> sysCfg.timerDisable && sysCfg.irqDisable)
    else $error("timers or interrupts active in reset");
  chk_pin_drive: assert property (@(posedge ref_clk) disable iff (rst)
    srcReq.porReq |=> resetPinNOe throughout (inReset [*1])) 
    else $error("reset pin not driven for power-on reset");
  chk_wdt_pin: assert property (@(posedge ref_clk) disable iff (rst)
    (srcReq.wdtReq && !drivePinReg && !srcReq.porReq && !srcReq.supplyReq) |=> !resetPinNOe)
    else $error("watchdog reset drove the reset pin");
  chk_release_sync: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(anySrc) |-> ##1 coreHalt [*3])
    else $error("release not held through synchroniser");
  chk_release_bound: assert property (@(posedge ref_clk) disable iff (rst)
    (coreHalt and relQuiet) |-> ##[0:2] vectorValid or !coreHalt)
    else $error("release did not complete in time");
  chk_boot_vec: assert property (@(posedge ref_clk) disable iff (rst)
    (stateReg == rbv_pkg::ST_SYNC && cntReg == 3'h1 && !anySrc && !syncBReg
      && sigByte == rbv_pkg::BOOT_SIGNATURE) |=> startVector == BOOT_VECTOR)
    else $error("bootloader vector not chosen");
  chk_zero_vec: assert property (@(posedge ref_clk) disable iff (rst)
    (stateReg == rbv_pkg::ST_SYNC && cntReg == 3'h1 && !anySrc && !syncBReg
      && sigByte != rbv_pkg::BOOT_SIGNATURE) |=> startVector == rbv_pkg::RESET_VECTOR)
    else $error("zero vector not chosen");
  chk_cfg_default: assert property (@(posedge ref_clk) disable iff (rst)
    inReset |=> cfgReg == rbv_pkg::CFG_RESET_VAL)
    else $error("register not at default after reset");

endmodule
